// ===== verilog/fcc_regs.sv
// Flash cache counters, erase guard, startup control and power-up registers
//
// Notes on behaviour
// - A one written to the counter-start bit clears both tallies and starts them from zero.
// - A one written to cache command bit 0 pulses the instruction cache invalidate output.
// - The hit tally is a read-only 20-bit count in bits 19:0 since the last start.
// - The miss tally is a separate read-only 20-bit count in bits 19:0 since the last start.
// - Writing 0x631A to the guard unlocks mass erase and any other value locks it again.
// - Reading the guard returns only bit 0, one while locked and zero while unlocked.
// - The guard is locked after reset and reads 0x0001.
// - Mass erase commands are not carried out while the guard is locked.
// - A one written to bit 0 of the flash command register starts the power-up sequence.
// - The end of the power-up sequence sets the power-up-complete flag.
// - The startup delay fields reset to a factory value given by a parameter.
// - When either tally saturates both stop and the counters-active bit clears.
// - Hit overflow sets flag bit 2 and miss overflow sets flag bit 3.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps
`include "fcc_defines.svh"
module fcc_regs #(
  parameter logic [31:0] STARTUP_RESET = `FCC_STARTUP_RST,
  parameter int          UNIT_CYC      = `FCC_DLY_UNIT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        cache_hit_i,
  input  wire logic        cache_miss_i,
  output logic             icache_invalidate_o,
  output logic             main_array_erase_cmd_o,
  output logic [2:0]       boot_wait_states_o,
  output logic             flash_waking_o,
  output logic             irq_o
);
  // ****************************************
  // Bus handshake: one wait cycle per access
  // ****************************************
  logic        ack;
  logic [31:0] startup;
  logic [15:0] guard_key;
  logic [5:0]  if_flags;
  logic [5:0]  ien;
  logic        active;
  logic        erase_cmd;
  wire req    = avs_read_i || avs_write_i;
  wire wr_acc = avs_write_i && ack;
  wire full_w = &avs_byteenable_i;
  assign avs_waitrequest_o = req && !ack;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= req && !ack;
    end
  end
  // ****************************************
  // Write decode
  // ****************************************
  wire wr_cc    = wr_acc && avs_address_i == `FCC_OFS_CACHECMD;
  wire wr_guard = wr_acc && avs_address_i == `FCC_OFS_ERASE_GUARD;
  wire wr_start = wr_acc && avs_address_i == `FCC_OFS_STARTUP;
  wire wr_fcmd  = wr_acc && avs_address_i == `FCC_OFS_FLASH_CMD;
  wire wr_ecmd  = wr_acc && avs_address_i == `FCC_OFS_ERASE_CMD;
  wire wr_if    = wr_acc && avs_address_i == `FCC_OFS_IF;
  wire wr_ien   = wr_acc && avs_address_i == `FCC_OFS_IEN;
  wire perf_count_start = wr_cc && avs_writedata_i[`FCC_CC_START];
  wire perf_count_stop  = wr_cc && avs_writedata_i[`FCC_CC_STOP];
  wire flash_wake_cmd   = wr_fcmd && avs_writedata_i[0];
  wire erase_locked     = (guard_key != `FCC_ERASE_KEY);
  // ****************************************
  // Tallies
  // ****************************************
  logic [19:0] hit_tally;
  logic [19:0] miss_tally;
  logic        hit_max;
  logic        miss_max;
  fcc_tally #(.WIDTH(20)) u_hits (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (perf_count_start),
    .run_i    (active),
    .event_i  (cache_hit_i),
    .count_o  (hit_tally),
    .at_max_o (hit_max)
  );
  fcc_tally #(.WIDTH(20)) u_misses (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (perf_count_start),
    .run_i    (active),
    .event_i  (cache_miss_i),
    .count_o  (miss_tally),
    .at_max_o (miss_max)
  );
  wire hit_of  = active && hit_max;
  wire miss_of = active && miss_max;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active <= 1'b0;
    end else if (perf_count_start) begin
      active <= 1'b1;
    end else if (perf_count_stop || hit_max || miss_max) begin
      active <= 1'b0;
    end
  end
  // ****************************************
  // Erase guard and startup control
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      guard_key <= `FCC_GUARD_RST;
      startup   <= STARTUP_RESET;
      erase_cmd <= 1'b0;
    end else begin
      if (wr_guard) begin
        guard_key <= avs_writedata_i[15:0];
      end
      if (wr_start && full_w) begin
        startup <= avs_writedata_i & `FCC_STARTUP_MASK;
      end
      erase_cmd <= wr_ecmd && avs_writedata_i[0] && !erase_locked;
    end
  end
  assign main_array_erase_cmd_o = erase_cmd;
  // ****************************************
  // Power-up sequencer
  // ****************************************
  logic wake_done;
  logic wake_busy;
  fcc_wake_seq #(.UNIT_CYC(UNIT_CYC)) u_wake (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .start_i       (flash_wake_cmd),
    .dly0_i        (startup[9:0]),
    .dly1_i        (startup[21:12]),
    .wait_states_i (startup[30:28]),
    .wait_always_i (startup[26]),
    .wait_en_i     (startup[25]),
    .active_wait_i (startup[24]),
    .busy_o        (wake_busy),
    .wait_states_o (boot_wait_states_o),
    .done_o        (wake_done)
  );
  assign flash_waking_o = wake_busy;
  // ****************************************
  // Interrupt flags: set wins over clear
  // ****************************************
  logic [5:0] ev;
  always_comb begin
    ev = 6'h00;
    ev[`FCC_IF_HITOF]  = hit_of;
    ev[`FCC_IF_MISSOF] = miss_of;
    ev[`FCC_IF_WAKE]   = wake_done;
  end
  wire [5:0] clr = wr_if ? avs_writedata_i[5:0] : 6'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if_flags <= 6'h00;
      ien      <= 6'h00;
    end else begin
      if_flags <= (if_flags & ~clr) | ev;
      if (wr_ien) begin
        ien <= avs_writedata_i[5:0];
      end
    end
  end
  assign irq_o = |(if_flags & ien);
  assign icache_invalidate_o = wr_cc && avs_writedata_i[`FCC_CC_INVAL];
  // ****************************************
  // Read mux
  // ****************************************
  logic [31:0] rdata;
  always_comb begin
    case (avs_address_i)
      `FCC_OFS_HITS:        rdata = {12'h000, hit_tally};
      `FCC_OFS_MISSES:      rdata = {12'h000, miss_tally};
      `FCC_OFS_ERASE_GUARD: rdata = {31'h00000000, erase_locked};
      `FCC_OFS_STARTUP:     rdata = startup;
      `FCC_OFS_IF:          rdata = {26'h0000000, if_flags};
      `FCC_OFS_IEN:         rdata = {26'h0000000, ien};
      `FCC_OFS_STATUS:      rdata = {25'h0000000, active, 5'h00, wake_busy};
      default:              rdata = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !ack) begin
      avs_readdata_o <= rdata;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  sequence s_start_cmd;
    perf_count_start;
  endsequence
  sequence s_key_write;
    wr_guard && avs_writedata_i[15:0] == `FCC_ERASE_KEY;
  endsequence
  sequence s_other_write;
    wr_guard && avs_writedata_i[15:0] != `FCC_ERASE_KEY;
  endsequence
  sequence s_guard_read;
    avs_read_i && !ack && avs_address_i == `FCC_OFS_ERASE_GUARD;
  endsequence
  sequence s_wake_cmd;
    flash_wake_cmd && !wake_busy;
  endsequence
  a_start_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    s_start_cmd
    |=> hit_tally == 20'h00000 && miss_tally == 20'h00000)
    else $error("tallies not cleared");
  a_inval_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cc && avs_writedata_i[0]
    |-> icache_invalidate_o)
    else $error("no invalidate");
  a_hit_count: assert property (@(posedge clk_i) disable iff (rst_i)
    active && cache_hit_i && !hit_max && !perf_count_start
    |=> hit_tally == $past(hit_tally) + 20'h00001)
    else $error("hit not counted");
  a_hit_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
    !active && !perf_count_start
    |=> $stable(hit_tally))
    else $error("hit tally moved while stopped");
  a_miss_count: assert property (@(posedge clk_i) disable iff (rst_i)
    active && cache_miss_i && !miss_max && !perf_count_start
    |=> miss_tally == $past(miss_tally) + 20'h00001)
    else $error("miss not counted");
  a_guard_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
    s_key_write
    |=> !erase_locked)
    else $error("key did not unlock");
  a_guard_relock: assert property (@(posedge clk_i) disable iff (rst_i)
    s_other_write
    |=> erase_locked)
    else $error("guard not relocked");
  a_guard_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    s_guard_read
    |=> avs_readdata_o == {31'h00000000, $past(erase_locked)})
    else $error("guard read value wrong");
  a_reset_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i)
    |-> erase_locked)
    else $error("guard open after reset");
  a_erase_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
    erase_locked
    |=> !main_array_erase_cmd_o)
    else $error("erase while locked");
  a_wake_start: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wake_cmd
    |=> wake_busy)
    else $error("power-up did not start");
  a_wake_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_done
    |=> if_flags[`FCC_IF_WAKE])
    else $error("wake flag missing");
  a_startup_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i)
    |-> startup == STARTUP_RESET)
    else $error("startup reset value wrong");
  a_stop_at_max: assert property (@(posedge clk_i) disable iff (rst_i)
    (hit_max || miss_max) && !perf_count_start
    |=> !active)
    else $error("counters still active");
  a_hit_of_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    hit_of && !perf_count_start
    |=> if_flags[`FCC_IF_HITOF] && !active)
    else $error("hit overflow flag missing");
  a_miss_of_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    miss_of
    |=> if_flags[`FCC_IF_MISSOF])
    else $error("miss overflow flag missing");
  a_wait_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wake_busy
    |-> boot_wait_states_o == 3'h0)
    else $error("wait states outside power-up");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (startup & ~`FCC_STARTUP_MASK) == 32'h00000000)
    else $error("reserved startup bits set");
endmodule

// ===== verilog/fcc_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FCC_DEFINES_SVH
`define FCC_DEFINES_SVH
// ****************************************
// Register offsets
// ****************************************
`define FCC_OFS_IF          12'h030
`define FCC_OFS_IEN         12'h03C
`define FCC_OFS_CACHECMD    12'h044
`define FCC_OFS_HITS        12'h048
`define FCC_OFS_MISSES      12'h04C
`define FCC_OFS_STATUS      12'h050
`define FCC_OFS_ERASE_GUARD 12'h054
`define FCC_OFS_ERASE_CMD   12'h058
`define FCC_OFS_STARTUP     12'h05C
`define FCC_OFS_FLASH_CMD   12'h074
// ****************************************
// Fields and values
// ****************************************
`define FCC_CC_INVAL        0
`define FCC_CC_START        1
`define FCC_CC_STOP         2
`define FCC_IF_HITOF        2
`define FCC_IF_MISSOF       3
`define FCC_IF_WAKE         4
`define FCC_ST_ACTIVE       6
`define FCC_ST_WAKING       0
`define FCC_ERASE_KEY       16'h631A
`define FCC_GUARD_RST       16'h0001
`define FCC_STARTUP_RST     32'h1300104D
`define FCC_STARTUP_MASK    32'h773FF3FF
`define FCC_TALLY_MAX       20'hFFFFF
`define FCC_DLY_UNIT_NS     1000
`define FCC_CLK_NS          25
`define FCC_DLY_UNIT_CYC    ((`FCC_DLY_UNIT_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS)
`endif

// ===== verilog/fcc_pkg.sv
// Types shared by the flash cache register block
package fcc_pkg;
  typedef enum logic [2:0] {
    FCC_IDLE,
    FCC_DLY0,
    FCC_DLY1,
    FCC_WAITST,
    FCC_DONE
  } fcc_wake_state_t;
endpackage

// ===== verilog/fcc_tally.sv
// Saturating 20-bit event tally
`timescale 1ns/100ps
`include "fcc_defines.svh"
module fcc_tally #(
  parameter int WIDTH = 20
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clear_i,
  input  wire logic             run_i,
  input  wire logic             event_i,
  output logic [WIDTH-1:0]      count_o,
  output logic                  at_max_o
);
  wire bump = run_i && event_i && !at_max_o;
  assign at_max_o = &count_o;
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count_o <= '0;
    end else if (bump) begin
      count_o <= count_o + 1'b1;
    end
  end
endmodule

// ===== verilog/fcc_wake_seq.sv
// Flash power-up sequencer with startup delays and wait states
`timescale 1ns/100ps
`include "fcc_defines.svh"
module fcc_wake_seq #(
  parameter int UNIT_CYC = `FCC_DLY_UNIT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [9:0]  dly0_i,
  input  wire logic [9:0]  dly1_i,
  input  wire logic [2:0]  wait_states_i,
  input  wire logic        wait_always_i,
  input  wire logic        wait_en_i,
  input  wire logic        active_wait_i,
  output logic             busy_o,
  output logic [2:0]       wait_states_o,
  output logic             done_o
);
  fcc_pkg::fcc_wake_state_t state;
  fcc_pkg::fcc_wake_state_t next_state;
  logic [9:0]  units;
  logic [15:0] tick;
  wire tick_en = (tick == 16'(UNIT_CYC - 1));
  wire units_done = tick_en && (units == 10'h000);
  always_comb begin
    next_state = state;
    case (state)
      fcc_pkg::FCC_IDLE:   if (start_i) next_state = fcc_pkg::FCC_DLY0;
      fcc_pkg::FCC_DLY0:   if (units_done) next_state = active_wait_i ? fcc_pkg::FCC_DLY1 : fcc_pkg::FCC_DONE;
      fcc_pkg::FCC_DLY1:   if (units_done) next_state = fcc_pkg::FCC_DONE;
      fcc_pkg::FCC_WAITST: next_state = fcc_pkg::FCC_DONE;
      fcc_pkg::FCC_DONE:   next_state = fcc_pkg::FCC_IDLE;
      default:             next_state = fcc_pkg::FCC_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= fcc_pkg::FCC_IDLE;
      tick  <= 16'h0000;
      units <= 10'h000;
    end else begin
      state <= next_state;
      tick  <= (state == fcc_pkg::FCC_IDLE || tick_en) ? 16'h0000 : tick + 16'h0001;
      if (state == fcc_pkg::FCC_IDLE) begin
        units <= dly0_i;
      end else if (state == fcc_pkg::FCC_DLY0 && units_done) begin
        units <= dly1_i;
      end else if (tick_en && units != 10'h000) begin
        units <= units - 10'h001;
      end
    end
  end
  assign busy_o = (state != fcc_pkg::FCC_IDLE);
  assign done_o = (state == fcc_pkg::FCC_DONE);
  // Wait states applied per enable bits
  assign wait_states_o = (busy_o && (wait_always_i || (wait_en_i && state == fcc_pkg::FCC_DLY1)))
                         ? wait_states_i : 3'h0;
endmodule

// ===== verif/testbench.sv
// Self-checking testbench for the flash cache register block
`timescale 1ns/100ps
`include "fcc_defines.svh"
module testbench;
  logic        clk_i;
  logic        rst_i;
  logic [11:0] avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        cache_hit_i;
  logic        cache_miss_i;
  logic        icache_invalidate_o;
  logic        main_array_erase_cmd_o;
  logic [2:0]  boot_wait_states_o;
  logic        flash_waking_o;
  logic        irq_o;
  int          n_mismatch;
  int          n_tests;
  int          n_inv;
  int          n_ers;
  logic [31:0] q;

  fcc_regs #(.UNIT_CYC(1)) i_fcc_regs (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .avs_address_i          (avs_address_i),
    .avs_read_i             (avs_read_i),
    .avs_write_i            (avs_write_i),
    .avs_writedata_i        (avs_writedata_i),
    .avs_byteenable_i       (avs_byteenable_i),
    .avs_readdata_o         (avs_readdata_o),
    .avs_waitrequest_o      (avs_waitrequest_o),
    .cache_hit_i            (cache_hit_i),
    .cache_miss_i           (cache_miss_i),
    .icache_invalidate_o    (icache_invalidate_o),
    .main_array_erase_cmd_o (main_array_erase_cmd_o),
    .boot_wait_states_o     (boot_wait_states_o),
    .flash_waking_o         (flash_waking_o),
    .irq_o                  (irq_o)
  );

  // ****************************************
  // Clock, pulse counters, watchdog
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (icache_invalidate_o === 1'b1) n_inv++;
    if (main_array_erase_cmd_o === 1'b1) n_ers++;
  end

  initial begin
    #(25 * 20000);
    n_mismatch++;
    stop_test();
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    chk("wait cycles", 32'd2, k);
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(name, exp, v & mask);
  endtask

  task automatic events(input int nh, input int nm);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      cache_hit_i  <= (i < nh);
      cache_miss_i <= (i < nm);
      @(posedge clk_i);
      cache_hit_i  <= 1'b0;
      cache_miss_i <= 1'b0;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values();
    rdchk("guard", `FCC_OFS_ERASE_GUARD, 32'hFFFFFFFF, 32'h00000001);
    rdchk("startup", `FCC_OFS_STARTUP, 32'hFFFFFFFF, `FCC_STARTUP_RST);
    rdchk("hits", `FCC_OFS_HITS, 32'hFFFFFFFF, 32'h00000000);
    rdchk("flags", `FCC_OFS_IF, 32'hFFFFFFFF, 32'h00000000);
    rdchk("unmapped", 12'h100, 32'hFFFFFFFF, 32'h00000000);
  endtask

  task automatic t_erase_guard();
    wr(`FCC_OFS_ERASE_CMD, 32'h00000001);
    repeat (3) @(posedge clk_i);
    chk("erase locked", 32'd0, n_ers);
    wr(`FCC_OFS_ERASE_GUARD, {16'h0000, `FCC_ERASE_KEY});
    rdchk("guard open", `FCC_OFS_ERASE_GUARD, 32'hFFFFFFFF, 32'h00000000);
    wr(`FCC_OFS_ERASE_CMD, 32'h00000001);
    repeat (3) @(posedge clk_i);
    chk("erase open", 32'd1, n_ers);
    wr(`FCC_OFS_ERASE_GUARD, 32'h0000631B);
    rdchk("guard relock", `FCC_OFS_ERASE_GUARD, 32'hFFFFFFFF, 32'h00000001);
    wr(`FCC_OFS_ERASE_CMD, 32'h00000001);
    repeat (3) @(posedge clk_i);
    chk("erase relocked", 32'd1, n_ers);
  endtask

  task automatic t_cache_cmds();
    wr(`FCC_OFS_CACHECMD, 32'h00000001);
    @(posedge clk_i);
    chk("invalidate", 32'd1, n_inv);
    events(4, 2);
    rdchk("hits idle", `FCC_OFS_HITS, 32'hFFFFFFFF, 32'h00000000);
    wr(`FCC_OFS_CACHECMD, 32'h00000002);
    rdchk("active", `FCC_OFS_STATUS, 32'h00000040, 32'h00000040);
    events(5, 3);
    rdchk("hits", `FCC_OFS_HITS, 32'hFFFFFFFF, 32'h00000005);
    rdchk("misses", `FCC_OFS_MISSES, 32'hFFFFFFFF, 32'h00000003);
    wr(`FCC_OFS_CACHECMD, 32'h00000004);
    events(2, 2);
    rdchk("hits stopped", `FCC_OFS_HITS, 32'hFFFFFFFF, 32'h00000005);
    rdchk("misses stopped", `FCC_OFS_MISSES, 32'hFFFFFFFF, 32'h00000003);
    wr(`FCC_OFS_HITS, 32'h000ABCDE);
    rdchk("hits ro", `FCC_OFS_HITS, 32'hFFFFFFFF, 32'h00000005);
    wr(`FCC_OFS_CACHECMD, 32'h00000002);
    rdchk("hits restart", `FCC_OFS_HITS, 32'hFFFFFFFF, 32'h00000000);
    rdchk("misses restart", `FCC_OFS_MISSES, 32'hFFFFFFFF, 32'h00000000);
    chk("no invalidate", 32'd1, n_inv);
  endtask

  task automatic t_wake();
    int k;
    logic [2:0] ws;
    ws = 3'h0;
    wr(`FCC_OFS_STARTUP, 32'hFFFFFFFF);
    rdchk("startup mask", `FCC_OFS_STARTUP, 32'hFFFFFFFF, `FCC_STARTUP_MASK);
    wr(`FCC_OFS_STARTUP, 32'h13002003);
    rdchk("startup", `FCC_OFS_STARTUP, 32'hFFFFFFFF, 32'h13002003);
    wr(`FCC_OFS_FLASH_CMD, 32'h00000001);
    k = 0;
    while (flash_waking_o !== 1'b1 && k < 10) begin
      @(posedge clk_i);
      k++;
    end
    chk("waking", 32'd1, {31'd0, flash_waking_o});
    chk("first delay wait states", 32'd0, {29'd0, boot_wait_states_o});
    while (flash_waking_o !== 1'b0 && k < 500) begin
      @(posedge clk_i);
      k++;
      ws = ws | boot_wait_states_o;
    end
    chk("woken", 32'd0, {31'd0, flash_waking_o});
    chk("second delay wait states", 32'd1, {29'd0, ws});
    chk("idle wait states", 32'd0, {29'd0, boot_wait_states_o});
    rdchk("done flag", `FCC_OFS_IF, 32'hFFFFFFFF, 32'h00000010);
    chk("irq masked", 32'd0, {31'd0, irq_o});
    wr(`FCC_OFS_IEN, 32'h00000010);
    @(posedge clk_i);
    chk("irq on", 32'd1, {31'd0, irq_o});
    wr(`FCC_OFS_IF, 32'h00000010);
    @(posedge clk_i);
    chk("irq off", 32'd0, {31'd0, irq_o});
    rdchk("flag cleared", `FCC_OFS_IF, 32'hFFFFFFFF, 32'h00000000);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    n_inv = 0;
    n_ers = 0;
    rst_i = 1'b1;
    avs_address_i = 12'h000;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h00000000;
    avs_byteenable_i = 4'hF;
    cache_hit_i = 1'b0;
    cache_miss_i = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_erase_guard();
    t_cache_cmds();
    t_wake();
    stop_test();
  end
endmodule
